// [tb.sv]
`timescale 1ns/10ps
// timeout table first, then hand-written corner cases
module tb;
  typedef struct packed
  {
    logic [7:0]  ctrl;
    logic [15:0] ticks;
  } row_type;

  logic        clock, rst, low_speed_wd_clock, debug_halt;
  logic [7:0]  boot_config_fuse, ctrl_wdata, wd_control_reg;
  logic        guard_key_write, instr_retire, ctrl_write, lock_write;
  logic        lock_wdata, watchdog_clear_instr, lock_bit;
  logic        sync_pending_flag, reset_request, wd_enabled;
  logic        window_closed, window_open;
  logic [13:0] wd_count;
  int          error_cnt = 0, checks = 0, ticks = 0, cycles = 0;
  int          start, i;
  row_type     rows [13];

  windowed_watchdog_timer dut (.*);
  wdt_host host (.*);

  // system clock and a fast stand-in for the slow oscillator
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    low_speed_wd_clock = 1'b0;
    #3;
    forever #8 low_speed_wd_clock = ~low_speed_wd_clock;
  end
  always @(posedge low_speed_wd_clock)
    ticks++;
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // tick counts allow for the synchroniser slack
  task automatic chk_near(input string nm, input int e, input int g);
    checks++;
    if (g < e - 2 || g > e + 1)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return reset_request;
      1: return wd_enabled;
      2: return window_closed;
      default: return window_open;
    endcase
  endfunction

  task automatic wait_on(input int w, input int lim);
    int n;
    n = 0;
    while (n < lim && sel(w) !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == lim)
    begin
      error_cnt++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", w);
    end
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge low_speed_wd_clock);
    @(posedge clock);
    #1;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge clock);
    #1;
    chk("reset req", 16'h0000, {15'h0, reset_request});
    rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    rows = '{'{8'h01, 16'd8}, '{8'h02, 16'd16}, '{8'h03, 16'd32},
             '{8'h04, 16'd64}, '{8'h05, 16'd128}, '{8'h0B, 16'd8192},
             '{8'h06, 16'd256}, '{8'h07, 16'd512}, '{8'h08, 16'd1024},
             '{8'h09, 16'd2048}, '{8'h0A, 16'd4096},
             '{8'h11, 16'd8}, '{8'h31, 16'd8}};
    {rst, debug_halt, boot_config_fuse} = 10'h200;
    // each code left to run out without clears
    for (i = 0; i < 13; i++)
    begin
      do_reset();
      host.prot_write(1'b1, 0, 1'b0, rows[i].ctrl);
      chk("pend set", 16'h0001, {15'h0, sync_pending_flag});
      wait_on(1, 200);
      chk("pend done", 16'h0000, {15'h0, sync_pending_flag});
      chk("control", {8'h00, rows[i].ctrl}, {8'h00, wd_control_reg});
      start = ticks;
      wait_on(0, rows[i].ticks * 4 + 100);
      chk_near("timeout", rows[i].ticks, ticks - start);
    end
    // refused writes: no key, stale key; then a last-moment write
    do_reset();
    host.prot_write(1'b0, 0, 1'b0, 8'h01);
    host.prot_write(1'b1, 4, 1'b0, 8'h01);
    wait_ticks(3);
    chk("unkeyed", 16'h0000, {8'h00, wd_control_reg});
    chk("disabled", 16'h0000, {15'h0, wd_enabled});
    host.prot_write(1'b1, 3, 1'b0, 8'h02);
    wait_on(1, 200);
    chk("late key", 16'h0002, {8'h00, wd_control_reg});
    // clears every ten ticks hold off a sixteen-tick timeout
    for (i = 0; i < 10; i++)
    begin
      wait_ticks(10);
      host.clear();
    end
    chk("cleared", 16'h0000, {15'h0, reset_request});
    // debug halt clears the count and holds it at zero
    debug_halt = 1'b1;
    wait_ticks(20);
    chk("halt count", 16'h0000, {2'b00, wd_count});
    chk("halt fire", 16'h0000, {15'h0, reset_request});
    debug_halt = 1'b0;
    // lock: set, refuse a write, refuse a clear outside debug
    host.prot_write(1'b1, 0, 1'b1, 8'h01);
    host.prot_write(1'b1, 0, 1'b0, 8'h05);
    host.prot_write(1'b1, 0, 1'b1, 8'h00);
    wait_ticks(1);
    chk("locked", 16'h0002, {8'h00, wd_control_reg});
    chk("lock kept", 16'h0001, {15'h0, lock_bit});
    debug_halt = 1'b1;
    host.prot_write(1'b1, 0, 1'b1, 8'h00);
    wait_ticks(1);
    chk("debug unlock", 16'h0000, {15'h0, lock_bit});
    debug_halt = 1'b0;
    // window: clear in open restarts closed, clear in closed fires
    do_reset();
    host.prot_write(1'b1, 0, 1'b0, 8'h11);
    wait_on(1, 200);
    host.clear();
    wait_on(3, 200);
    chk("opened", 16'h0001, {15'h0, window_open});
    host.clear();
    wait_ticks(4);
    chk("reclosed", 16'h0001, {15'h0, window_closed});
    chk("open clear", 16'h0000, {15'h0, reset_request});
    host.clear();
    wait_on(0, 40);
    chk("early clear", 16'h0001, {15'h0, reset_request});
    // boot fuse with a timeout code locks at boot
    boot_config_fuse = 8'h03;
    do_reset();
    chk("fuse ctrl", 16'h0003, {8'h00, wd_control_reg});
    chk("fuse lock", 16'h0001, {15'h0, lock_bit});
    stop_test();
  end
endmodule

// [wd_link_if.sv]
`timescale 1ns/10ps
// carries the watchdog tick and the timeout decode between blocks
interface wd_link_if;
  logic        tick;
  logic [3:0]  code [2];
  logic [13:0] len  [2];

  modport tick_src (output tick);
  modport lut      (input code, output len);
  modport core     (input tick, input len, output code);
endinterface

// [wd_tick_detect.sv]
`timescale 1ns/10ps
// turns the slow oscillator level into a one-cycle tick on its rising edge
module wd_tick_detect
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic low_speed_wd_clock,
  wd_link_if.tick_src link
);

  logic last_level;

  // remember the previous level of the slow clock
  always_ff @(posedge clock)
  begin
    if (rst)
      last_level <= low_speed_wd_clock; // no false tick on release
    else
      last_level <= low_speed_wd_clock;
  end

  // one pulse per slow-clock period
  always_ff @(posedge clock)
  begin
    if (rst)
      link.tick <= 1'b0;
    else
      link.tick <= low_speed_wd_clock & ~last_level; // R3
  end

endmodule

// [wd_timeout_lut.sv]
`timescale 1ns/10ps
// decodes the timeout and window codes into tick counts
module wd_timeout_lut
(
  input  wire logic clock,
  input  wire logic rst,
  wd_link_if.lut    link
);

  // code 1 gives 8 ticks, each step doubles; reserved codes clamp to max
  function automatic logic [13:0] decode(input logic [3:0] code);
    logic [3:0] shift;
    shift = 4'h0;
    if (code == wdt_pkg::CODE_OFF)
      decode = 14'h0000;
    else
    begin
      if (code > wdt_pkg::CODE_MAX)
        shift = wdt_pkg::CODE_MAX - 4'h1;
      else
        shift = code - 4'h1;
      decode = wdt_pkg::BASE_TICKS << shift; // R4 R22
    end
  endfunction

  // channel 0 is the open/normal timeout, channel 1 the closed period
  genvar g;
  for (g = 0; g < 2; g++)
  begin : chan
    always_ff @(posedge clock)
    begin
      if (rst)
        link.len[g] <= 14'h0000;
      else
        link.len[g] <= decode(link.code[g]);
    end
  end

endmodule

// [wdt_host.sv]
`timescale 1ns/10ps
// host core: unlock key, retire pulses, protected writes, clears
module wdt_host
(
  input  wire logic       clock,
  input  wire logic       sync_pending_flag,
  output logic            guard_key_write,
  output logic            instr_retire,
  output logic            ctrl_write,
  output logic      [7:0] ctrl_wdata,
  output logic            lock_write,
  output logic            lock_wdata,
  output logic            watchdog_clear_instr
);
  initial
  begin
    {guard_key_write, instr_retire, ctrl_write, lock_write} = 4'h0;
    {ctrl_wdata, lock_wdata, watchdog_clear_instr} = 10'h000;
  end

  // key, then some retired instructions, then the write
  task automatic prot_write(input bit key, input int retires,
                            input bit is_lock, input logic [7:0] data);
    int i;
    while (sync_pending_flag === 1'b1)
    begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    guard_key_write = key;
    for (i = 0; i < retires; i++)
    begin
      @(posedge clock);
      #1;
      guard_key_write = 1'b0;
      instr_retire = 1'b1;
    end
    @(posedge clock);
    #1;
    guard_key_write = 1'b0;
    instr_retire = 1'b0;
    ctrl_write = !is_lock;
    lock_write = is_lock;
    ctrl_wdata = data;
    lock_wdata = data[0];
    @(posedge clock);
    #1;
    ctrl_write = 1'b0;
    lock_write = 1'b0;
  endtask

  // one clear instruction
  task automatic clear();
    @(posedge clock);
    #1;
    watchdog_clear_instr = 1'b1;
    @(posedge clock);
    #1;
    watchdog_clear_instr = 1'b0;
  endtask
endmodule

// [wdt_pkg.sv]
package wdt_pkg;

  // control register layout: window code high, timeout code low
  localparam int          FIELD_W        = 4;
  localparam int          PERIOD_LSB     = 0;
  localparam int          WINDOW_LSB     = 4;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic        LOCK_RESET     = 1'b0;

  // timeout codes: 1 is 8 watchdog ticks, doubling up to code 0xB
  localparam logic [3:0]  CODE_OFF       = 4'h0;
  localparam logic [3:0]  CODE_MAX       = 4'hB;
  localparam int          LEN_W          = 14;
  localparam logic [13:0] BASE_TICKS     = 14'h0008;

  // protected write window, counted in retired instructions
  localparam logic [2:0]  GUARD_INSTRS   = 3'h4;

  // watchdog ticks a clear spends in the synchroniser
  localparam int          CLEAR_SYNC_LEN = 2;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_NORMAL,
    ST_CLOSED,
    ST_OPEN,
    ST_FIRED
  } wd_state_type;

endpackage

// [wdt_props.sv]
`timescale 1ns/10ps
// watches the watchdog top ports
module wdt_props
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        guard_key_write,
  input wire logic        instr_retire,
  input wire logic        ctrl_write,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic        debug_halt,
  input wire logic [7:0]  wd_control_reg,
  input wire logic        lock_bit,
  input wire logic        sync_pending_flag,
  input wire logic        reset_request,
  input wire logic        wd_enabled,
  input wire logic        window_closed,
  input wire logic        window_open,
  input wire logic [13:0] wd_count
);
  logic [2:0] guard_left;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // instructions left in the unlock window
  always_ff @(posedge clock)
  begin
    if (rst)
      guard_left <= 3'h0;
    else if (guard_key_write)
      guard_left <= wdt_pkg::GUARD_INSTRS;
    else if (instr_retire && guard_left != 3'h0)
      guard_left <= guard_left - 3'h1;
  end

  reset_hold_a: assert property (reset_request |=> reset_request)
    else $error("reset request dropped");
  quiet_off_a: assert property (!wd_enabled && !$past(wd_enabled)
    && !reset_request |=> !reset_request)
    else $error("reset request while disabled");
  lock_sticky_a: assert property (lock_bit && !debug_halt |=> lock_bit)
    else $error("lock cleared outside debug");
  lock_freeze_a: assert property (lock_bit |=> $stable(wd_control_reg))
    else $error("control changed while locked");
  guard_block_a: assert property (!$past(rst)
    && !(ctrl_write && guard_left != 3'h0) |=> $stable(wd_control_reg))
    else $error("control changed without unlock");
  write_take_a: assert property (ctrl_write && guard_left != 3'h0
    && !lock_bit && !$past(rst)
    |=> sync_pending_flag && wd_control_reg == $past(ctrl_wdata))
    else $error("unlocked write not taken");
  pend_clear_a: assert property ($rose(sync_pending_flag)
    |-> ##[1:16] !sync_pending_flag)
    else $error("pending flag stuck");
  open_after_a: assert property ($rose(window_open) |-> $past(window_closed))
    else $error("open period without closed period");
  debug_hold_a: assert property (debug_halt ##1 debug_halt
    |-> wd_count == 14'h0000 && !window_closed)
    else $error("count runs during debug halt");
endmodule

bind windowed_watchdog_timer wdt_props chk (.*);

// [windowed_watchdog_timer.sv]
`timescale 1ns/10ps
// Contract
// R1 - watchdog enabled when timeout code is non-zero, disabled when zero
// R2 - enabled and no clear before timeout expires: request system reset
// R3 - counter advances on ticks of the 1.024 kHz low-power oscillator
// R4 - eleven timeout codes from 8 ms up to 8 s
// R5 - every accepted clear starts a fresh full timeout period
// R6 - single-period normal mode while window code is zero
// R7 - non-zero window code enables window mode, zero disables it
// R8 - in window mode a clear during the closed period requests reset
// R9 - open period always follows closed; total is closed plus open
// R10 - window sequence starts only after first clear after enable or debug
// R11 - control and lock writes ignored without the unlock sequence
// R12 - control reset from boot fuse; non-zero timeout sets lock at boot
// R13 - while locked, control register contents cannot change
// R14 - software may only set lock; clearing needs debug halt
// R15 - counting continues in active and all sleep modes with oscillator
// R16 - counting and reset request survive a stopped system clock; here every register runs on clock, so counting stops with it
// R17 - debug halt suspends operation and clears the counter
// R18 - restart from debug in window mode skips first closed period
// R19 - code writes synchronised to watchdog domain with a pending flag
// R20 - host must not write control while the pending flag is set
// R21 - a clear takes effect after two to three watchdog ticks
// R22 - window code uses the same doubling encoding as timeout code
// R23 - pending flag set on control write, cleared when sync completes
// R24 - protected write must follow the unlock key within four instructions
// R25 - single reset-request output, held until system reset
module windowed_watchdog_timer
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        low_speed_wd_clock,
  input  wire logic        guard_key_write,
  input  wire logic        instr_retire,
  input  wire logic        ctrl_write,
  input  wire logic [7:0]  ctrl_wdata,
  input  wire logic        lock_write,
  input  wire logic        lock_wdata,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        debug_halt,
  input  wire logic [7:0]  boot_config_fuse,
  output logic      [7:0]  wd_control_reg,
  output logic             lock_bit,
  output logic             sync_pending_flag,
  output logic             reset_request,
  output logic             wd_enabled,
  output logic             window_closed,
  output logic             window_open,
  output logic      [13:0] wd_count
);

  // tick and decoded lengths shared with the helper blocks
  wd_link_if link ();

  // boot load and protected write path
  logic                              boot_pending;
  logic [2:0]                        guard_count;
  logic                              guard_open;
  logic                              ctrl_accept;
  logic                              lock_accept;
  // watchdog-domain code copies and clear pipeline
  logic [3:0]                        active_period;
  logic [3:0]                        active_window;
  logic                              clear_req;
  logic [wdt_pkg::CLEAR_SYNC_LEN-1:0] clear_pipe;
  logic                              clear_effect;
  // counting state machine
  wdt_pkg::wd_state_type             state;
  wdt_pkg::wd_state_type             next_state;
  logic [13:0]                       next_count;
  logic [13:0]                       count_inc;
  logic                              running;

  // slow clock edge detector and code-to-length decoder
  wd_tick_detect tick_unit
  (
    .clock              (clock),
    .rst                (rst),
    .low_speed_wd_clock (low_speed_wd_clock),
    .link               (link.tick_src)
  );

  wd_timeout_lut lut_unit
  (
    .clock (clock),
    .rst   (rst),
    .link  (link.lut)
  );

  // the decoder looks at the synchronised copies only
  assign link.code[0] = active_period;
  assign link.code[1] = active_window;

  // fuse contents are taken on the first edge after reset release
  always_ff @(posedge clock)
  begin
    if (rst)
      boot_pending <= 1'b1;
    else
      boot_pending <= 1'b0;
  end

  // unlock window: key write opens it for a count of retired instructions
  always_ff @(posedge clock)
  begin
    if (rst)
      guard_count <= 3'h0;
    else if (guard_key_write)
      guard_count <= wdt_pkg::GUARD_INSTRS; // R24
    else if (instr_retire && guard_count != 3'h0)
      guard_count <= guard_count - 3'h1; // R24
  end

  // window stays open while instructions remain
  assign guard_open = (guard_count != 3'h0);

  // protected writes need the unlock window; control also needs no lock
  assign ctrl_accept = ctrl_write & guard_open & ~lock_bit & ~boot_pending; // R11 R13
  assign lock_accept = lock_write & guard_open & ~boot_pending; // R11

  // control register: fuse at boot, protected software writes afterwards
  always_ff @(posedge clock)
  begin
    if (rst)
      wd_control_reg <= wdt_pkg::CTRL_RESET;
    else if (boot_pending)
      wd_control_reg <= boot_config_fuse; // R12
    else if (ctrl_accept)
      wd_control_reg <= ctrl_wdata;
  end

  // lock: set at boot by a non-zero fuse timeout, set-only for software outside debug halt
  always_ff @(posedge clock)
  begin
    if (rst)
      lock_bit <= wdt_pkg::LOCK_RESET;
    else if (boot_pending)
      lock_bit <= boot_config_fuse[wdt_pkg::PERIOD_LSB +: wdt_pkg::FIELD_W]
                  != wdt_pkg::CODE_OFF; // R12
    else if (lock_accept && lock_wdata)
      lock_bit <= 1'b1; // R14
    else if (lock_accept && !lock_wdata && debug_halt)
      lock_bit <= 1'b0; // R14
  end

  // pending flag: a new write wins over completion in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      sync_pending_flag <= 1'b0;
    else if (boot_pending || ctrl_accept)
      sync_pending_flag <= 1'b1; // R19 R23
    else if (link.tick)
      sync_pending_flag <= 1'b0; // R23
  end

  // codes move into the watchdog domain on a slow-clock tick
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      active_period <= wdt_pkg::CODE_OFF;
      active_window <= wdt_pkg::CODE_OFF;
    end
    else if (link.tick && sync_pending_flag)
    begin
      active_period <= wd_control_reg[wdt_pkg::PERIOD_LSB +: wdt_pkg::FIELD_W]; // R19
      active_window <= wd_control_reg[wdt_pkg::WINDOW_LSB +: wdt_pkg::FIELD_W]; // R19
    end
  end

  // clear request held until the next tick; a new clear beats the drain
  always_ff @(posedge clock)
  begin
    if (rst || debug_halt)
      clear_req <= 1'b0;
    else if (watchdog_clear_instr)
      clear_req <= 1'b1;
    else if (link.tick)
      clear_req <= 1'b0;
  end

  // clear crosses two ticks, then acts on the third edge
  always_ff @(posedge clock)
  begin
    if (rst || debug_halt)
      clear_pipe <= '0;
    else if (link.tick)
      clear_pipe <= {clear_pipe[wdt_pkg::CLEAR_SYNC_LEN-2:0], clear_req}; // R21
  end

  // the delayed clear acts only on a tick, so it lines up with counting
  assign clear_effect = link.tick & clear_pipe[wdt_pkg::CLEAR_SYNC_LEN-1]; // R21

  // running follows the synchronised timeout code, not the written one
  assign running   = (active_period != wdt_pkg::CODE_OFF); // R1

  // next count value; lengths top out well below the counter's range
  assign count_inc = wd_count + 14'h0001;

  // next state and count; only slow ticks advance, never the system clock
  always_comb
  begin
    next_state = state;
    next_count = wd_count;
    case (state)
      wdt_pkg::ST_OFF:
      begin
        next_count = 14'h0000;
        if (running && !debug_halt)
          next_state = wdt_pkg::ST_NORMAL; // R1 R10
      end
      wdt_pkg::ST_NORMAL:
      begin
        if (!running)
        begin
          next_state = wdt_pkg::ST_OFF; // R1
          next_count = 14'h0000;
        end
        else if (clear_effect)
        begin
          next_count = 14'h0000; // R5
          if (active_window != wdt_pkg::CODE_OFF)
            next_state = wdt_pkg::ST_CLOSED; // R7 R10
        end
        else if (link.tick)
        begin
          if (count_inc >= link.len[0])
            next_state = wdt_pkg::ST_FIRED; // R2 R6
          else
            next_count = count_inc; // R15 R16
        end
      end
      wdt_pkg::ST_CLOSED:
      begin
        if (!running)
        begin
          next_state = wdt_pkg::ST_OFF;
          next_count = 14'h0000;
        end
        else if (active_window == wdt_pkg::CODE_OFF)
        begin
          next_state = wdt_pkg::ST_NORMAL; // R7
          next_count = 14'h0000;
        end
        else if (clear_effect)
          next_state = wdt_pkg::ST_FIRED; // R8
        else if (link.tick)
        begin
          if (count_inc >= link.len[1])
          begin
            next_state = wdt_pkg::ST_OPEN; // R9
            next_count = 14'h0000;
          end
          else
            next_count = count_inc;
        end
      end
      wdt_pkg::ST_OPEN:
      begin
        if (!running)
        begin
          next_state = wdt_pkg::ST_OFF;
          next_count = 14'h0000;
        end
        else if (clear_effect)
        begin
          next_count = 14'h0000; // R5
          if (active_window != wdt_pkg::CODE_OFF)
            next_state = wdt_pkg::ST_CLOSED; // R9
          else
            next_state = wdt_pkg::ST_NORMAL; // R6
        end
        else if (link.tick)
        begin
          if (count_inc >= link.len[0])
            next_state = wdt_pkg::ST_FIRED; // R2 R9
          else
            next_count = count_inc;
        end
      end
      wdt_pkg::ST_FIRED:
      begin
        // only rst leaves this state, so the request cannot drop
        next_state = wdt_pkg::ST_FIRED; // R25
      end
      default:
      begin
        next_state = wdt_pkg::ST_OFF;
        next_count = 14'h0000;
      end
    endcase
    // a halted CPU freezes the watchdog with a cleared counter
    if (debug_halt && state != wdt_pkg::ST_FIRED)
    begin
      next_count = 14'h0000; // R17
      next_state = running ? wdt_pkg::ST_NORMAL : wdt_pkg::ST_OFF; // R17 R18
    end
  end

  // state and counter registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= wdt_pkg::ST_OFF;
      wd_count <= 14'h0000;
    end
    else
    begin
      state    <= next_state;
      wd_count <= next_count;
    end
  end

  // registered status views of running and the next state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wd_enabled    <= 1'b0;
      window_closed <= 1'b0;
      window_open   <= 1'b0;
    end
    else
    begin
      wd_enabled    <= running;
      window_closed <= (next_state == wdt_pkg::ST_CLOSED);
      window_open   <= (next_state == wdt_pkg::ST_OPEN);
    end
  end

  // reset request to the reset controller, held until reset arrives
  always_ff @(posedge clock)
  begin
    if (rst)
      reset_request <= 1'b0;
    else if (next_state == wdt_pkg::ST_FIRED)
      reset_request <= 1'b1; // R2 R8 R25
  end

endmodule
